// ==== pkg/rlcd_pkg.sv ====
// constants, types and decoders for remote capability and link detect
package rlcd_pkg;

  // register offsets
  localparam logic [7:0] CAP_LOW_ADDR      = 8'h20;
  localparam logic [7:0] CAP_HIGH_ADDR     = 8'h21;
  localparam logic [7:0] LINK_TIMEOUT_ADDR = 8'h26;

  // reset values
  localparam logic [7:0] CAP_LOW_RESET  = 8'h00;
  localparam logic [1:0] CAP_HIGH_RESET = 2'h0;
  localparam logic [2:0] TIMEOUT_RESET  = 3'h0;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // field positions
  localparam int CAP_HIGH_MODE_LSB = 0;
  localparam int CAP_HIGH_MODE_MSB = 1;
  localparam int TIMEOUT_SEL_LSB   = 0;
  localparam int TIMEOUT_SEL_MSB   = 2;
  localparam int PORT_COUNT        = 2;

  // timing
  localparam int CLOCK_PERIOD_NS  = 4;
  localparam int TIMEOUT_162US_NS = 162000;
  localparam int TIMEOUT_325US_NS = 325000;
  localparam int TIMEOUT_650US_NS = 650000;
  localparam int TIMEOUT_1MS3_NS  = 1300000;
  localparam int TIMEOUT_10US_NS  = 10250;
  localparam int TIMEOUT_20US_NS  = 20500;
  localparam int TIMEOUT_41US_NS  = 41000;
  localparam int TIMEOUT_82US_NS  = 82000;
  localparam int TIMEOUT_10US_CYCLES = TIMEOUT_10US_NS / CLOCK_PERIOD_NS;
  localparam int TIMER_WIDTH      = 19;
  localparam logic [18:0] TIMER_ONE  = 19'h00001;
  localparam logic [18:0] TIMER_ZERO = 19'h00000;

  // fast control channel mode codes
  typedef enum logic [2:0] {
    FCC_NORMAL   = 3'b000,
    FCC_FAST_1   = 3'b001,
    FCC_FAST_2   = 3'b010,
    FCC_FAST_4   = 3'b011,
    FCC_RESV_4   = 3'b100,
    FCC_RESV_5   = 3'b101,
    FCC_FWD_SPI  = 3'b110,
    FCC_REV_SPI  = 3'b111
  } rlcd_fcc_mode_type;

  // first capability register layout, bit 7 down to bit 0
  typedef struct packed {
    logic capability_freeze;
    logic mode_low;
    logic send_freq;
    logic send_eq;
    logic remote_two_link_capable;
    logic channel_role;
    logic full_colour_with_hd_sound;
    logic forward_frame_io_capable;
  } rlcd_cap_low_type;

  // capability word delivered by the reverse control channel
  typedef struct packed {
    logic [2:0] fast_control_channel_mode;
    logic       send_freq;
    logic       send_eq;
    logic       remote_two_link_capable;
    logic       channel_role;
    logic       full_colour_with_hd_sound;
    logic       forward_frame_io_capable;
  } rlcd_rx_caps_type;

  // reserved codes and unknown values fall back to the normal frame
  function automatic rlcd_fcc_mode_type rlcd_decode_mode(
    input logic [2:0] code
  );
    rlcd_decode_mode = FCC_NORMAL;
    if ((code != FCC_RESV_4) && (code != FCC_RESV_5)) begin
      rlcd_decode_mode = rlcd_fcc_mode_type'(code);
    end
  endfunction

  // true when a mode uses the high-speed back channel
  function automatic logic rlcd_is_fast(input logic [2:0] code);
    rlcd_is_fast = (rlcd_decode_mode(code) != FCC_NORMAL);
  endfunction

endpackage

// ==== hdl/rlcd_cap_bank.sv ====
// capability storage for one link: software writes, auto load, freeze
`timescale 1ns/1ps
module rlcd_cap_bank (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // reverse control channel
  input  wire logic                       rx_lock,
  input  wire logic                       caps_valid,
  input  wire rlcd_pkg::rlcd_rx_caps_type rx_caps,
  // software access
  input  wire logic                       write_low,
  input  wire logic                       write_high,
  input  wire logic [7:0]                 write_data,
  // stored values
  output rlcd_pkg::rlcd_cap_low_type      cap_low,
  output logic [1:0]                      mode_high
);

  logic                       auto_load;
  logic [2:0]                 loaded_mode;
  rlcd_pkg::rlcd_cap_low_type next_low;

  assign auto_load = rx_lock && caps_valid &&
                     !cap_low.capability_freeze;
  // an auto load from a single-link remote only gets the normal frame mode
  assign loaded_mode = rx_caps.remote_two_link_capable ?
                       rx_caps.fast_control_channel_mode :
                       rlcd_pkg::FCC_NORMAL;
  assign next_low = '{
    capability_freeze:         cap_low.capability_freeze,
    mode_low:                  loaded_mode[0],
    send_freq:                 rx_caps.send_freq,
    send_eq:                   rx_caps.send_eq,
    remote_two_link_capable:   rx_caps.remote_two_link_capable,
    channel_role:              rx_caps.channel_role,
    full_colour_with_hd_sound: rx_caps.full_colour_with_hd_sound,
    forward_frame_io_capable:  rx_caps.forward_frame_io_capable
  };

  // software write has priority over an auto load in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cap_low <= rlcd_pkg::CAP_LOW_RESET;
    end else if (write_low) begin
      cap_low <= write_data;
    end else if (auto_load) begin
      cap_low <= next_low;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_high <= rlcd_pkg::CAP_HIGH_RESET;
    end else if (write_high) begin
      mode_high <= write_data[rlcd_pkg::CAP_HIGH_MODE_MSB:
                              rlcd_pkg::CAP_HIGH_MODE_LSB];
    end else if (auto_load) begin
      mode_high <= loaded_mode[2:1];
    end
  end

endmodule

// ==== hdl/rlcd_link_timer.sv ====
// link detect timeout for one link
`timescale 1ns/1ps
module rlcd_link_timer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // traffic and timeout
  input  wire logic        rx_valid,
  input  wire logic [18:0] limit,
  // state
  output logic             link_detect
);

  logic [18:0] count;
  logic [18:0] next_count;
  logic        expired;

  assign next_count = count + rlcd_pkg::TIMER_ONE;
  assign expired    = (next_count >= limit);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= rlcd_pkg::TIMER_ZERO;
    end else if (rx_valid || !link_detect) begin
      count <= rlcd_pkg::TIMER_ZERO;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_detect <= 1'b0;
    end else if (rx_valid) begin
      link_detect <= 1'b1;
    end else if (expired) begin
      link_detect <= 1'b0;
    end
  end

endmodule

// ==== hdl/rlcd_top.sv ====
// remote capability registers and link detect timers for two links
// Function
// - once receiver locks, capability fields load from the control channel
// - software may write capabilities; freeze bit stops automatic loads
// - second port select shows and writes the second link's capabilities
// - a flag reports whether the remote receiver supports two links
// - bit 2 gives the remote channel role: 0 primary, 1 secondary
// - a flag reports full-colour video together with high-definition sound
// - bit 0 of the first register reports forward-frame I/O support
// - three-bit fast mode: upper bits at second register 1:0, low in first
// - modes: normal, 1/2/4 fast lines, two reserved, forward, reverse SPI
// - auto loads from single-link remotes only get the normal back-channel frame mode
// - link detect drops after the timeout with no valid reverse traffic
// - timeout select picks 162, 325, 650us, 1.3ms, 10.25, 20.5, 41, 82us
// - freeze bit is bit 7 of the first register and blocks loading
// - lowest fast mode bit is bit 6 of the first register
`timescale 1ns/1ps
module rlcd_top #(
  parameter int TIMEOUT_162US_CYCLES =
    rlcd_pkg::TIMEOUT_162US_NS / rlcd_pkg::CLOCK_PERIOD_NS,
  parameter int TIMEOUT_325US_CYCLES =
    rlcd_pkg::TIMEOUT_325US_NS / rlcd_pkg::CLOCK_PERIOD_NS,
  parameter int TIMEOUT_650US_CYCLES =
    rlcd_pkg::TIMEOUT_650US_NS / rlcd_pkg::CLOCK_PERIOD_NS,
  parameter int TIMEOUT_1MS3_CYCLES  =
    rlcd_pkg::TIMEOUT_1MS3_NS / rlcd_pkg::CLOCK_PERIOD_NS,
  parameter int TIMEOUT_20US_CYCLES  =
    rlcd_pkg::TIMEOUT_20US_NS / rlcd_pkg::CLOCK_PERIOD_NS,
  parameter int TIMEOUT_41US_CYCLES  =
    rlcd_pkg::TIMEOUT_41US_NS / rlcd_pkg::CLOCK_PERIOD_NS,
  parameter int TIMEOUT_82US_CYCLES  =
    rlcd_pkg::TIMEOUT_82US_NS / rlcd_pkg::CLOCK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                             CLOCK,
  input  wire logic                             RSTN,
  // register port
  input  wire logic [7:0]                       REG_ADDR,
  input  wire logic                             REG_WRITE,
  input  wire logic [7:0]                       REG_WDATA,
  input  wire logic                             REG_READ,
  output logic [7:0]                            REG_RDATA,
  output logic                                  REG_RACK,
  // port selection
  input  wire logic                             SECOND_PORT_SELECT,
  // reverse control channel, one entry per link
  input  wire logic [1:0]                       RX_LOCK,
  input  wire logic [1:0]                       RX_CAPS_VALID,
  input  wire rlcd_pkg::rlcd_rx_caps_type [1:0] RX_CAPS,
  input  wire logic [1:0]                       RX_TRAFFIC_VALID,
  // link state
  output logic [1:0]                            LINK_DETECT,
  // capabilities of each link
  output logic [1:0]                            REMOTE_TWO_LINK_CAPABLE,
  output logic [1:0]                            REMOTE_CHANNEL_ROLE,
  output logic [1:0]                            FULL_COLOUR_WITH_HD_SOUND,
  output logic [1:0]                            FORWARD_FRAME_IO_CAPABLE,
  output logic [1:0]                            CAPABILITY_FREEZE,
  output rlcd_pkg::rlcd_fcc_mode_type [1:0]     FAST_CONTROL_CHANNEL_MODE,
  output logic [1:0]                            FAST_CONTROL_CHANNEL_ON
);

  // address match used by the write and read decoders
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    addr_hit = (addr == offset);
  endfunction

  // decode
  logic       hit_low;
  logic       hit_high;
  logic       hit_timeout;
  logic [1:0] port_write_low;
  logic [1:0] port_write_high;
  logic       sel_port;

  // storage
  rlcd_pkg::rlcd_cap_low_type [1:0] cap_low;
  logic [1:0][1:0]                  mode_high;
  logic [2:0]                       timeout_sel;

  // timing
  logic [18:0]      limit;
  logic [7:0][18:0] limit_table;

  // read path
  logic [7:0] read_low;
  logic [7:0] read_high;
  logic [7:0] read_timeout;
  logic [7:0] next_rdata;

  // per link mode
  logic [1:0][2:0] mode_code;
  logic [1:0]      link_detect;

  assign sel_port    = SECOND_PORT_SELECT;
  assign hit_low     = addr_hit(REG_ADDR, rlcd_pkg::CAP_LOW_ADDR);
  assign hit_high    = addr_hit(REG_ADDR, rlcd_pkg::CAP_HIGH_ADDR);
  assign hit_timeout = addr_hit(REG_ADDR, rlcd_pkg::LINK_TIMEOUT_ADDR);

  // timeout table, indexed by the 3-bit select
  assign limit_table[0] = TIMEOUT_162US_CYCLES[18:0];
  assign limit_table[1] = TIMEOUT_325US_CYCLES[18:0];
  assign limit_table[2] = TIMEOUT_650US_CYCLES[18:0];
  assign limit_table[3] = TIMEOUT_1MS3_CYCLES[18:0];
  assign limit_table[4] = rlcd_pkg::TIMEOUT_10US_CYCLES[18:0];
  assign limit_table[5] = TIMEOUT_20US_CYCLES[18:0];
  assign limit_table[6] = TIMEOUT_41US_CYCLES[18:0];
  assign limit_table[7] = TIMEOUT_82US_CYCLES[18:0];
  assign limit          = limit_table[timeout_sel];

  // timeout select register
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      timeout_sel <= rlcd_pkg::TIMEOUT_RESET;
    end else if (REG_WRITE && hit_timeout) begin
      timeout_sel <= REG_WDATA[rlcd_pkg::TIMEOUT_SEL_MSB:
                               rlcd_pkg::TIMEOUT_SEL_LSB];
    end
  end

  // per link storage, timer and output registers
  for (genvar p = 0; p < rlcd_pkg::PORT_COUNT; p++) begin : g_link
    assign port_write_low[p]  = REG_WRITE && hit_low &&
                                (sel_port == 1'(p));
    assign port_write_high[p] = REG_WRITE && hit_high &&
                                (sel_port == 1'(p));
    assign mode_code[p] = {mode_high[p],
                           cap_low[p].mode_low};

    rlcd_cap_bank u_bank (
      .clock      (CLOCK),
      .rstn       (RSTN),
      .rx_lock    (RX_LOCK[p]),
      .caps_valid (RX_CAPS_VALID[p]),
      .rx_caps    (RX_CAPS[p]),
      .write_low  (port_write_low[p]),
      .write_high (port_write_high[p]),
      .write_data (REG_WDATA),
      .cap_low    (cap_low[p]),
      .mode_high  (mode_high[p])
    );

    rlcd_link_timer u_timer (
      .clock       (CLOCK),
      .rstn        (RSTN),
      .rx_valid    (RX_TRAFFIC_VALID[p]),
      .limit       (limit),
      .link_detect (link_detect[p])
    );

    always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
        LINK_DETECT[p]               <= 1'b0;
        REMOTE_TWO_LINK_CAPABLE[p]   <= 1'b0;
        REMOTE_CHANNEL_ROLE[p]       <= 1'b0;
        FULL_COLOUR_WITH_HD_SOUND[p] <= 1'b0;
        FORWARD_FRAME_IO_CAPABLE[p]  <= 1'b0;
        CAPABILITY_FREEZE[p]         <= 1'b0;
        FAST_CONTROL_CHANNEL_MODE[p] <= rlcd_pkg::FCC_NORMAL;
        FAST_CONTROL_CHANNEL_ON[p]   <= 1'b0;
      end else begin
        LINK_DETECT[p]               <= link_detect[p];
        REMOTE_TWO_LINK_CAPABLE[p]   <=
          cap_low[p].remote_two_link_capable;
        REMOTE_CHANNEL_ROLE[p]       <= cap_low[p].channel_role;
        FULL_COLOUR_WITH_HD_SOUND[p] <=
          cap_low[p].full_colour_with_hd_sound;
        FORWARD_FRAME_IO_CAPABLE[p]  <=
          cap_low[p].forward_frame_io_capable;
        CAPABILITY_FREEZE[p]         <= cap_low[p].capability_freeze;
        FAST_CONTROL_CHANNEL_MODE[p] <=
          rlcd_pkg::rlcd_decode_mode(mode_code[p]);
        FAST_CONTROL_CHANNEL_ON[p]   <=
          rlcd_pkg::rlcd_is_fast(mode_code[p]);
      end
    end
  end

  // read selection, registered one cycle after the read strobe
  assign read_low     = cap_low[sel_port];
  assign read_high    = {6'h00, mode_high[sel_port]};
  assign read_timeout = {5'h00, timeout_sel};
  assign next_rdata   = hit_low     ? read_low :
                        hit_high    ? read_high :
                        hit_timeout ? read_timeout :
                        rlcd_pkg::READ_ZERO;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= rlcd_pkg::READ_ZERO;
      REG_RACK  <= 1'b0;
    end else begin
      REG_RACK <= REG_READ;
      if (REG_READ) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

endmodule

// ==== verification/rlcd_monitor.sv ====
// assertion checker for the capability registers and link timers
`timescale 1ns/1ps
module rlcd_monitor (
  // clock and reset
  input wire logic                              CLOCK,
  input wire logic                              RSTN,
  // register port
  input wire logic [7:0]                        REG_ADDR,
  input wire logic                              REG_WRITE,
  input wire logic [7:0]                        REG_WDATA,
  input wire logic                              REG_READ,
  input wire logic [7:0]                        REG_RDATA,
  input wire logic                              REG_RACK,
  input wire logic                              SECOND_PORT_SELECT,
  // reverse channel and link state
  input wire logic [1:0]                        RX_LOCK,
  input wire logic [1:0]                        RX_CAPS_VALID,
  input wire rlcd_pkg::rlcd_rx_caps_type [1:0]  RX_CAPS,
  input wire logic [1:0]                        RX_TRAFFIC_VALID,
  input wire logic [1:0]                        LINK_DETECT,
  input wire logic [1:0]                        FORWARD_FRAME_IO_CAPABLE,
  input wire logic [1:0]                        CAPABILITY_FREEZE,
  input wire rlcd_pkg::rlcd_fcc_mode_type [1:0] FAST_CONTROL_CHANNEL_MODE,
  input wire logic [1:0]                        FAST_CONTROL_CHANNEL_ON
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence load0_s;
    RX_LOCK[0] && RX_CAPS_VALID[0] && !CAPABILITY_FREEZE[0] && !REG_WRITE
      && !$past(REG_WRITE);
  endsequence
  a_read_answer: assert property (REG_READ |=> REG_RACK)
    else $error("read without answer");
  a_answer_cause: assert property (REG_RACK |-> $past(REG_READ))
    else $error("answer without read");
  a_timeout_reserved: assert property (
    REG_READ && REG_ADDR == rlcd_pkg::LINK_TIMEOUT_ADDR
      |=> REG_RDATA[7:3] == 5'h00) else $error("timeout reserved bits set");
  a_detect_rise: assert property (
    RX_TRAFFIC_VALID[0] |-> ##2 LINK_DETECT[0])
    else $error("link detect not raised");
  a_detect_fall: assert property (
    $fell(LINK_DETECT[0]) |-> !$past(RX_TRAFFIC_VALID[0], 2)
      && !$past(RX_TRAFFIC_VALID[0], 3)) else $error("detect fell early");
  a_auto_load: assert property (load0_s |-> ##2
    FORWARD_FRAME_IO_CAPABLE[0] ==
      $past(RX_CAPS[0].forward_frame_io_capable, 2))
    else $error("capability not loaded");
  a_single_link: assert property (
    load0_s ##0 !RX_CAPS[0].remote_two_link_capable
      |-> ##2 FAST_CONTROL_CHANNEL_MODE[0] == rlcd_pkg::FCC_NORMAL)
    else $error("single link remote got fast mode");
  a_freeze_holds: assert property (
    CAPABILITY_FREEZE[0] && !$past(REG_WRITE)
      |=> $stable(FORWARD_FRAME_IO_CAPABLE[0])) else $error("frozen changed");
  a_second_port: assert property (
    REG_WRITE && REG_ADDR == rlcd_pkg::CAP_LOW_ADDR && SECOND_PORT_SELECT
      |-> ##2 CAPABILITY_FREEZE[1] == $past(REG_WDATA[7], 2))
    else $error("second port write lost");
  a_mode_flag: assert property (
    FAST_CONTROL_CHANNEL_ON[0] ==
      (FAST_CONTROL_CHANNEL_MODE[0] != rlcd_pkg::FCC_NORMAL)
      && FAST_CONTROL_CHANNEL_MODE[0] != rlcd_pkg::FCC_RESV_4
      && FAST_CONTROL_CHANNEL_MODE[0] != rlcd_pkg::FCC_RESV_5)
    else $error("mode output inconsistent");
endmodule
bind rlcd_top rlcd_monitor monitor (
  .CLOCK, .RSTN, .REG_ADDR, .REG_WRITE, .REG_WDATA, .REG_READ, .REG_RDATA,
  .REG_RACK, .SECOND_PORT_SELECT, .RX_LOCK, .RX_CAPS_VALID, .RX_CAPS,
  .RX_TRAFFIC_VALID, .LINK_DETECT, .FORWARD_FRAME_IO_CAPABLE,
  .CAPABILITY_FREEZE, .FAST_CONTROL_CHANNEL_MODE, .FAST_CONTROL_CHANNEL_ON
);

// ==== verification/rlcd_remote_model.sv ====
// behavioural remote receiver driving the reverse control channel
`timescale 1ns/1ps
module rlcd_remote_model (
  // clock
  input wire logic                         clock,
  // reverse control channel
  output logic [1:0]                       rx_lock,
  output logic [1:0]                       caps_valid,
  output rlcd_pkg::rlcd_rx_caps_type [1:0] rx_caps,
  output logic [1:0]                       traffic_valid
);
  initial begin
    rx_lock = 2'h0;
    caps_valid = 2'h0;
    rx_caps = 18'h3ffff;
    traffic_valid = 2'h0;
  end
  task automatic send_caps(input int p, input rlcd_pkg::rlcd_rx_caps_type w);
    @(posedge clock);
    #1;
    rx_lock[p] = 1'b1;
    caps_valid[p] = 1'b1;
    rx_caps[p] = w;
    @(posedge clock);
    #1;
    caps_valid[p] = 1'b0;
    rx_caps[p] = ~w;
  endtask
  task automatic send_traffic(input int p);
    @(posedge clock);
    #1;
    traffic_valid[p] = 1'b1;
    @(posedge clock);
    #1;
    traffic_valid[p] = 1'b0;
  endtask
endmodule

// ==== verification/rlcd_bench.sv ====
// self-checking bench for the capability registers and link timers
`timescale 1ns/1ps
module rlcd_bench;
  logic                              clock = 1'b0;
  logic                              rstn = 1'b0;
  logic [7:0]                        reg_addr = 8'h00;
  logic                              reg_write = 1'b0;
  logic [7:0]                        reg_wdata = 8'h00;
  logic                              reg_read = 1'b0;
  logic [7:0]                        reg_rdata;
  logic                              reg_rack;
  logic                              port_sel = 1'b0;
  logic [1:0]                        rx_lock, caps_valid, traffic, detect;
  logic [1:0]                        fast_on;
  logic [1:0]                        two_link, role, colour, fwd_io, freeze;
  rlcd_pkg::rlcd_rx_caps_type [1:0]  rx_caps;
  rlcd_pkg::rlcd_fcc_mode_type [1:0] fast_mode;
  int                                mismatches = 0;
  int                                total_checks = 0;
  int                                cycles = 0;
  int                                limits [8] = '{40, 80, 160, 320,
    rlcd_pkg::TIMEOUT_10US_CYCLES,
    rlcd_pkg::TIMEOUT_20US_NS / rlcd_pkg::CLOCK_PERIOD_NS,
    rlcd_pkg::TIMEOUT_41US_NS / rlcd_pkg::CLOCK_PERIOD_NS,
    rlcd_pkg::TIMEOUT_82US_NS / rlcd_pkg::CLOCK_PERIOD_NS};
  rlcd_remote_model remote (.clock(clock), .rx_lock(rx_lock),
    .caps_valid(caps_valid), .rx_caps(rx_caps), .traffic_valid(traffic));
  rlcd_top #(.TIMEOUT_162US_CYCLES(40), .TIMEOUT_325US_CYCLES(80),
    .TIMEOUT_650US_CYCLES(160), .TIMEOUT_1MS3_CYCLES(320)) DUT (
    .CLOCK(clock), .RSTN(rstn),
    .REG_ADDR(reg_addr), .REG_WRITE(reg_write), .REG_WDATA(reg_wdata),
    .REG_READ(reg_read), .REG_RDATA(reg_rdata), .REG_RACK(reg_rack),
    .SECOND_PORT_SELECT(port_sel), .RX_LOCK(rx_lock),
    .RX_CAPS_VALID(caps_valid), .RX_CAPS(rx_caps),
    .RX_TRAFFIC_VALID(traffic), .LINK_DETECT(detect),
    .REMOTE_TWO_LINK_CAPABLE(two_link), .REMOTE_CHANNEL_ROLE(role),
    .FULL_COLOUR_WITH_HD_SOUND(colour), .FORWARD_FRAME_IO_CAPABLE(fwd_io),
    .CAPABILITY_FREEZE(freeze), .FAST_CONTROL_CHANNEL_MODE(fast_mode),
    .FAST_CONTROL_CHANNEL_ON(fast_on));
  always #2 clock = ~clock;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 45000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // capability outputs of one link: freeze, two link, role, colour, io
  function automatic logic [7:0] caps_of(input int p);
    caps_of = {3'h0, freeze[p], two_link[p], role[p], colour[p], fwd_io[p]};
  endfunction
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    wait_cycles(1);
    reg_write = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_read = 1'b1;
    wait_cycles(1);
    check("read answer", {7'h00, reg_rack}, 8'h01);
    check("read data", reg_rdata, exp);
    reg_read = 1'b0;
  endtask
  initial begin
    wait_cycles(10);
    rstn = 1'b1;
    reg_rd(8'h20, 8'h00);
    reg_rd(8'h21, 8'h00);
    reg_rd(8'h26, 8'h00);
    reg_rd(8'h22, 8'h00);
    reg_wr(8'h21, 8'hfe);
    reg_rd(8'h21, 8'h02);
    remote.send_caps(0, 9'h18d);
    wait_cycles(1);
    check("mode", {5'h00, fast_mode[0]}, 8'h06);
    check("link0 caps", caps_of(0), 8'h0d);
    reg_rd(8'h20, 8'h0d);
    reg_rd(8'h21, 8'h03);
    port_sel = 1'b1;
    remote.send_caps(1, 9'h0c2);
    reg_rd(8'h20, 8'h02);
    reg_rd(8'h21, 8'h00);
    check("link1 caps", caps_of(1), 8'h02);
    reg_wr(8'h20, 8'h80);
    reg_rd(8'h20, 8'h80);
    check("link1 frozen", caps_of(1), 8'h10);
    port_sel = 1'b0;
    reg_rd(8'h20, 8'h0d);
    for (int m = 0; m < 8; m++) begin
      reg_wr(8'h20, {1'b1, m[0], 6'h00});
      reg_wr(8'h21, {6'h00, m[2:1]});
      wait_cycles(2);
      check("mode", {5'h00, fast_mode[0]},
            (m == 4 || m == 5) ? 8'h00 : 8'(m));
      check("fast on", {7'h00, fast_on[0]},
            (m == 0 || m == 4 || m == 5) ? 8'h00 : 8'h01);
      reg_rd(8'h20, {1'b1, m[0], 6'h00});
    end
    remote.send_caps(0, 9'h18d);
    reg_rd(8'h20, 8'hc0);
    for (int s = 0; s < 8; s++) begin
      reg_wr(8'h26, 8'(s));
      remote.send_traffic(0);
      wait_cycles(5);
      remote.send_traffic(0);
      wait_cycles(limits[s]);
      check("detect held", {7'h00, detect[0]}, 8'h01);
      wait_cycles(1);
      check("detect lost", {7'h00, detect[0]}, 8'h00);
    end
    stop_test();
  end
endmodule
